// ### logic/ioc_pkg.sv
package ioc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int unsigned IOC_DO_W  = 8;
    localparam int unsigned IOC_AN_W  = 16;
    localparam int unsigned IOC_AI_N  = 8;
    localparam int unsigned IOC_AO_N  = 8;
    localparam int unsigned IOC_CH_W  = 3;

    ////////////////////////////////////////////////////////////////////////////
    // object indices
    localparam logic [15:0] IOC_IDX_DO_IMAGE = 16'h6200;
    localparam logic [15:0] IOC_IDX_DO_MASK  = 16'h6206;
    localparam logic [15:0] IOC_IDX_DO_FVAL  = 16'h6207;
    localparam logic [15:0] IOC_IDX_AI       = 16'h6401;
    localparam logic [15:0] IOC_IDX_AO       = 16'h6411;
    localparam logic [15:0] IOC_IDX_AO_MODE  = 16'h6443;
    localparam logic [15:0] IOC_IDX_AO_FVAL  = 16'h6444;

    // sub-indices and counts
    localparam logic [7:0]  IOC_SUB_COUNT    = 8'h00;
    localparam logic [7:0]  IOC_SUB_FIRST    = 8'h01;
    localparam logic [7:0]  IOC_DO_COUNT     = 8'h01;
    localparam logic [7:0]  IOC_AI_COUNT     = 8'h08;
    localparam logic [7:0]  IOC_AO_COUNT     = 8'h08;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and codes
    localparam logic [7:0]  IOC_DO_IMAGE_RST = 8'h00;
    localparam logic [7:0]  IOC_DO_MASK_RST  = 8'h00;
    localparam logic [7:0]  IOC_DO_FVAL_RST  = 8'h00;
    localparam logic [15:0] IOC_AN_RST       = 16'h0000;
    localparam logic [15:0] IOC_AO_MODE_RST  = 16'h0000;
    localparam logic [15:0] IOC_AO_FVAL_RST  = 16'h0000;
    localparam logic [15:0] IOC_AO_FAULT_ON  = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [15:0] wdata;
    } ioc_od_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } ioc_od_rsp_t;

    typedef struct packed {
        logic signed [15:0] hi;
        logic signed [15:0] lo;
    } ioc_ai_range_t;

    typedef struct packed {
        logic        code;
        logic        mode;
        logic        fval;
        logic [15:0] data;
    } ioc_ao_wr_t;

    typedef struct packed {
        logic [15:0] code;
        logic [15:0] mode;
        logic [15:0] fval;
    } ioc_ao_st_t;

    typedef struct packed {
        logic [IOC_DO_W-1:0]                doImage;
        logic [IOC_DO_W-1:0]                doMask;
        logic [IOC_DO_W-1:0]                doFval;
        logic [IOC_AI_N-1:0][IOC_AN_W-1:0]  aiValue;
        ioc_od_rsp_t                        rsp;
    } ioc_main_st_t;

endpackage

// ### logic/ioc_ai_clamp.sv
`timescale 1ns/10ps
module ioc_ai_clamp
    import ioc_pkg::*;
(
    input  wire logic signed [IOC_AN_W-1:0] sample,
    input  wire ioc_ai_range_t              range,
    output logic signed [IOC_AN_W-1:0]      clamped
);

    // signed compare: codes are two's complement, never floating point
    always_comb begin
        clamped = sample;
        if (sample > range.hi) begin
            clamped = range.hi; // [R10]
        end else if (sample < range.lo) begin
            clamped = range.lo; // [R11]
        end
    end

endmodule

// ### logic/ioc_ao_channel.sv
`timescale 1ns/10ps
module ioc_ao_channel
    import ioc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire ioc_ao_wr_t wr,
    input  wire logic       faultEvt,
    output ioc_ao_st_t      st
);

    ioc_ao_st_t state_q;
    ioc_ao_st_t state_d;

    always_comb begin
        state_d = state_q;
        if (wr.code) begin
            state_d.code = wr.data; // [R12]
        end
        if (wr.mode) begin
            state_d.mode = wr.data;
        end
        if (wr.fval) begin
            state_d.fval = wr.data;
        end
        // fault wins over a code write in the same cycle
        if (faultEvt && state_q.mode == IOC_AO_FAULT_ON) begin // [R13]
            state_d.code = state_q.fval; // [R14]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q.code <= IOC_AN_RST;
            state_q.mode <= IOC_AO_MODE_RST; // [R15]
            state_q.fval <= IOC_AO_FVAL_RST; // [R15]
        end else begin
            state_q <= state_d;
        end
    end

    assign st = state_q;

endmodule

// ### logic/ioc_io_image.sv
`timescale 1ns/10ps
// What this block does
// [R1] 8-bit read-write image drives digital outputs
// [R2] bus-off or guarding failure consults digital mask
// [R3] masked channels take matching fault value bit
// [R4] bit n maps to digital channel n
// [R5] unmasked digital channels keep their state
// [R6] digital fault mask resets to zero
// [R7] digital fault value resets to zero
// [R8] analog inputs read-only 16-bit two's complement
// [R9] analog input count read-only, eight
// [R10] samples above range maximum saturate to maximum
// [R11] samples below range minimum saturate to minimum
// [R12] 16-bit read-write code per analog output
// [R13] analog fault mode one enables substitution
// [R14] enabled analog outputs take their fault code
// [R15] analog fault mode and value reset zero
// [R16] master writes two's complement codes, no float
module ioc_io_image
    import ioc_pkg::*;
(
    input  wire logic                               sys_clk,
    input  wire logic                               arst_n,
    input  wire ioc_od_req_t                        odReq,
    output ioc_od_rsp_t                             odRsp,
    input  wire logic                               busOff,
    input  wire logic                               guardFail,
    input  wire logic [IOC_AI_N-1:0][IOC_AN_W-1:0]  aiSample,
    input  wire logic [IOC_AI_N-1:0]                aiStrobe,
    input  wire ioc_ai_range_t [IOC_AI_N-1:0]       aiRange,
    output logic [IOC_DO_W-1:0]                     doOut,
    output logic [IOC_AO_N-1:0][IOC_AN_W-1:0]       aoOut
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic chanHit(input logic [7:0] sub, input logic [7:0] count);
        chanHit = (sub >= IOC_SUB_FIRST) && (sub <= count);
    endfunction

    function automatic logic [IOC_CH_W-1:0] chanOf(input logic [7:0] sub);
        logic [7:0] diff;
        diff   = sub - IOC_SUB_FIRST;
        chanOf = diff[IOC_CH_W-1:0];
    endfunction

    function automatic logic [15:0] widen8(input logic [7:0] v);
        widen8 = {8'h00, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    ioc_main_st_t                          state_q;
    ioc_main_st_t                          state_d;
    logic                                  faultEvt;
    logic [IOC_AI_N-1:0][IOC_AN_W-1:0]     aiClamped;
    ioc_ao_wr_t                            aoWr [IOC_AO_N];
    ioc_ao_st_t                            aoSt [IOC_AO_N];

    // either error event triggers the same substitution
    assign faultEvt = busOff | guardFail; // [R2]

    ////////////////////////////////////////////////////////////////////////////
    // analog channels

    for (genvar i = 0; i < IOC_AI_N; i++) begin : g_ai
        ioc_ai_clamp u_clamp (
            .sample  (aiSample[i]),
            .range   (aiRange[i]),
            .clamped (aiClamped[i])
        );
    end

    for (genvar j = 0; j < IOC_AO_N; j++) begin : g_ao
        ioc_ao_channel u_ch (
            .sys_clk  (sys_clk),
            .arst_n   (arst_n),
            .wr       (aoWr[j]),
            .faultEvt (faultEvt),
            .st       (aoSt[j])
        );
        assign aoOut[j] = aoSt[j].code;
    end

    ////////////////////////////////////////////////////////////////////////////
    // object access and fault substitution

    always_comb begin
        logic [IOC_CH_W-1:0] ch;
        logic                isCount;
        logic                isChanAi;
        logic                isChanAo;
        ch       = chanOf(odReq.sub);
        isCount  = (odReq.sub == IOC_SUB_COUNT);
        isChanAi = chanHit(odReq.sub, IOC_AI_COUNT);
        isChanAo = chanHit(odReq.sub, IOC_AO_COUNT);
        state_d  = state_q;
        state_d.rsp = '0;
        for (int k = 0; k < IOC_AO_N; k++) begin
            aoWr[k]      = '0;
            aoWr[k].data = odReq.wdata;
        end

        // samples are stored already saturated
        for (int k = 0; k < IOC_AI_N; k++) begin
            if (aiStrobe[k]) begin
                state_d.aiValue[k] = aiClamped[k]; // [R10] [R11]
            end
        end

        if (odReq.valid) begin
            state_d.rsp.ack = 1'b1;
            unique case (odReq.index)
                IOC_IDX_DO_IMAGE: begin
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_DO_COUNT);
                        state_d.rsp.err   = odReq.write;
                    end else if (chanHit(odReq.sub, IOC_DO_COUNT)) begin
                        state_d.rsp.rdata = widen8(state_q.doImage);
                        if (odReq.write) begin
                            state_d.doImage = odReq.wdata[IOC_DO_W-1:0]; // [R1] [R4]
                        end
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                IOC_IDX_DO_MASK: begin
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_DO_COUNT);
                        state_d.rsp.err   = odReq.write;
                    end else if (chanHit(odReq.sub, IOC_DO_COUNT)) begin
                        state_d.rsp.rdata = widen8(state_q.doMask);
                        if (odReq.write) begin
                            state_d.doMask = odReq.wdata[IOC_DO_W-1:0];
                        end
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                IOC_IDX_DO_FVAL: begin
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_DO_COUNT);
                        state_d.rsp.err   = odReq.write;
                    end else if (chanHit(odReq.sub, IOC_DO_COUNT)) begin
                        state_d.rsp.rdata = widen8(state_q.doFval);
                        if (odReq.write) begin
                            state_d.doFval = odReq.wdata[IOC_DO_W-1:0];
                        end
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                IOC_IDX_AI: begin
                    // read-only: every write is refused
                    state_d.rsp.err = odReq.write; // [R8] [R9]
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_AI_COUNT); // [R9]
                    end else if (isChanAi) begin
                        state_d.rsp.rdata = state_q.aiValue[ch]; // [R8]
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                IOC_IDX_AO: begin
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_AO_COUNT);
                        state_d.rsp.err   = odReq.write;
                    end else if (isChanAo) begin
                        state_d.rsp.rdata = aoSt[ch].code;
                        aoWr[ch].code     = odReq.write; // [R12]
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                IOC_IDX_AO_MODE: begin
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_AO_COUNT);
                        state_d.rsp.err   = odReq.write;
                    end else if (isChanAo) begin
                        state_d.rsp.rdata = aoSt[ch].mode;
                        aoWr[ch].mode     = odReq.write;
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                IOC_IDX_AO_FVAL: begin
                    if (isCount) begin
                        state_d.rsp.rdata = widen8(IOC_AO_COUNT);
                        state_d.rsp.err   = odReq.write;
                    end else if (isChanAo) begin
                        state_d.rsp.rdata = aoSt[ch].fval;
                        aoWr[ch].fval     = odReq.write;
                    end else begin
                        state_d.rsp.err = 1'b1;
                    end
                end
                default: begin
                    // unmapped object: abort, nothing changes
                    state_d.rsp.err = 1'b1;
                end
            endcase
        end

        // applied after any write so the fault wins a same-cycle collision
        if (faultEvt) begin
            state_d.doImage = (state_d.doImage & ~state_q.doMask) // [R5]
                            | (state_q.doFval & state_q.doMask);  // [R3] [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q.doImage <= IOC_DO_IMAGE_RST;
            state_q.doMask  <= IOC_DO_MASK_RST; // [R6]
            state_q.doFval  <= IOC_DO_FVAL_RST; // [R7]
            state_q.aiValue <= '0;
            state_q.rsp     <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign doOut = state_q.doImage;
    assign odRsp = state_q.rsp;

endmodule

// ### testbench/ioc_io_image_checker.sv
`timescale 1ns/10ps
module ioc_io_image_checker
    import ioc_pkg::*;
(
    input wire logic                              sys_clk,
    input wire logic                              arst_n,
    input wire ioc_od_req_t                       odReq,
    input wire ioc_od_rsp_t                       odRsp,
    input wire logic                              busOff,
    input wire logic                              guardFail,
    input wire logic [IOC_DO_W-1:0]               doOut,
    input wire logic [IOC_AO_N-1:0][IOC_AN_W-1:0] aoOut
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic       flt;
    logic       wrReq;
    logic [7:0] wLow;
    assign flt   = busOff | guardFail;
    assign wrReq = odReq.valid & odReq.write;
    assign wLow  = odReq.wdata[7:0];
    ////////////////////////////////////////////////////////////////////////////
    property p_ack;
        odReq.valid |=> odRsp.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_idle;
        !odReq.valid |=> !odRsp.ack && !odRsp.err;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_do_wr;
        wrReq && odReq.index == IOC_IDX_DO_IMAGE && odReq.sub == IOC_SUB_FIRST && !flt |=> doOut == $past(wLow);
    endproperty
    a_do_wr: assert property (p_do_wr) else $error("digital image write lost");
    // outputs may only move on a write or a fault event
    property p_do_hold;
        !flt && !wrReq |=> $stable(doOut);
    endproperty
    a_do_hold: assert property (p_do_hold) else $error("digital outputs moved");
    property p_ao_hold;
        !flt && !wrReq |=> $stable(aoOut);
    endproperty
    a_ao_hold: assert property (p_ao_hold) else $error("analog outputs moved");
    property p_ai_ro;
        wrReq && odReq.index == IOC_IDX_AI |=> odRsp.ack && odRsp.err;
    endproperty
    a_ai_ro: assert property (p_ai_ro) else $error("analog input write accepted");
    property p_cnt;
        odReq.valid && !odReq.write && odReq.index == IOC_IDX_AI && odReq.sub == IOC_SUB_COUNT
            |=> odRsp.rdata == 16'h0008 && !odRsp.err;
    endproperty
    a_cnt: assert property (p_cnt) else $error("analog input count wrong");
    property p_cnt_ro;
        wrReq && odReq.sub == IOC_SUB_COUNT && odReq.index == IOC_IDX_AI |-> ##1 odRsp.err;
    endproperty
    a_cnt_ro: assert property (p_cnt_ro) else $error("count entry write accepted");
    c_flt: cover property (flt);
    c_ao_wr: cover property (wrReq && odReq.index == IOC_IDX_AO);
    c_err: cover property (odRsp.err);
endmodule

// ### testbench/ioc_master_model.sv
`timescale 1ns/10ps
module ioc_master_model
    import ioc_pkg::*;
(
    input  wire logic        sys_clk,
    output ioc_od_req_t      odReq,
    input  wire ioc_od_rsp_t odRsp
);
    initial odReq = '0;
    // codes go out as raw two's-complement words, never float
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
                          input logic [15:0] wd, output logic [15:0] rd, output logic er);
        @(negedge sys_clk);
        odReq <= '{1'b1, wr, idx, sb, wd};
        @(negedge sys_clk);
        rd = odRsp.rdata;
        er = odRsp.err | ~odRsp.ack;
        odReq <= '0;
    endtask
endmodule

// ### testbench/canopen_io_fault_outputs_tb_top.sv
`timescale 1ns/10ps
module canopen_io_fault_outputs_tb_top;
    import ioc_pkg::*;
    logic                              sys_clk, arst_n, busOff, guardFail, er;
    ioc_od_req_t                       odReq;
    ioc_od_rsp_t                       odRsp;
    logic [IOC_AI_N-1:0][IOC_AN_W-1:0] aiSample;
    logic [IOC_AI_N-1:0]               aiStrobe;
    ioc_ai_range_t [IOC_AI_N-1:0]      aiRange;
    logic [IOC_DO_W-1:0]               doOut;
    logic [IOC_AO_N-1:0][IOC_AN_W-1:0] aoOut;
    logic [15:0]                       rd;
    int                                fail_count, cmp_count, doImg, doMsk, doFv, lo, hi, s, e;
    int                                aoCode[8], aoMode[8], aoFv[8];
    ioc_io_image dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .odReq(odReq), .odRsp(odRsp), .busOff(busOff),
        .guardFail(guardFail), .aiSample(aiSample), .aiStrobe(aiStrobe), .aiRange(aiRange), .doOut(doOut),
        .aoOut(aoOut));
    ioc_master_model mdl_u (.sys_clk(sys_clk), .odReq(odReq), .odRsp(odRsp));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sb, input logic [15:0] wd);
        mdl_u.access(wr, idx, sb, wd, rd, er);
    endtask
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] sb, input int exp);
        acc(1'b0, idx, sb, 16'h0000);
        chk(er, 0);
        chk(rd, exp);
    endtask
    // one-cycle fault event; outputs settle by the next falling edge
    task automatic evt(input bit g);
        @(negedge sys_clk);
        if (g) guardFail <= 1'b1;
        else busOff <= 1'b1;
        @(negedge sys_clk);
        guardFail <= 1'b0;
        busOff <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, busOff, guardFail, aiSample, aiStrobe, aiRange} = '0;
        void'($urandom(32'h4daa63dd));
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        rdchk(IOC_IDX_DO_MASK, 1, 0);
        rdchk(IOC_IDX_DO_FVAL, 1, 0);
        for (int k = 1; k <= 8; k++) begin
            rdchk(IOC_IDX_AO_MODE, k[7:0], 0);
            rdchk(IOC_IDX_AO_FVAL, k[7:0], 0);
        end
        rdchk(IOC_IDX_AI, 0, 8);
        acc(1'b1, IOC_IDX_AI, 0, 16'h0003);
        chk(er, 1);
        acc(1'b1, IOC_IDX_AI, 1, 16'h1234);
        chk(er, 1);
        acc(1'b0, 16'h6000, 1, 16'h0000);
        chk(er, 1);
        $display("reset and count test done");
        for (int i = 0; i < 4; i++) begin
            doImg = $urandom & 255;
            doMsk = (i == 0) ? 32'h31 : $urandom & 255;
            doFv = (i == 0) ? 32'hF8 : $urandom & 255;
            acc(1'b1, IOC_IDX_DO_IMAGE, 1, doImg[15:0]);
            chk(doOut, doImg);
            acc(1'b1, IOC_IDX_DO_MASK, 1, doMsk[15:0]);
            acc(1'b1, IOC_IDX_DO_FVAL, 1, doFv[15:0]);
            rdchk(IOC_IDX_DO_MASK, 1, doMsk);
            evt(i[0]);
            doImg = (doImg & ~doMsk) | (doFv & doMsk);
            chk(doOut, doImg);
        end
        rdchk(IOC_IDX_DO_FVAL, 1, doFv);
        acc(1'b1, IOC_IDX_DO_MASK, 0, 16'h0001);
        chk(er, 1);
        // write and fault land on one edge: masked bits must still take the fault value
        doImg = $urandom & 255;
        fork
            evt(1'b0);
            acc(1'b1, IOC_IDX_DO_IMAGE, 1, doImg[15:0]);
        join
        chk(doOut, (doImg & ~doMsk) | (doFv & doMsk));
        rdchk(IOC_IDX_DO_IMAGE, 1, (doImg & ~doMsk) | (doFv & doMsk));
        $display("digital fault test done");
        for (int k = 0; k < 8; k++) begin
            lo = -int'($urandom % 20000);
            hi = int'($urandom % 20000);
            s = (k % 3 == 0) ? hi + 1 + int'($urandom % 100) : (k % 3 == 1) ? lo - 1 - int'($urandom % 100)
                : lo + int'($urandom % (hi - lo + 1));
            aiRange[k] = '{hi[15:0], lo[15:0]};
            aiSample[k] = s[15:0];
        end
        @(negedge sys_clk);
        aiStrobe <= '1;
        @(negedge sys_clk);
        aiStrobe <= '0;
        for (int k = 0; k < 8; k++) begin
            lo = $signed(aiRange[k].lo);
            hi = $signed(aiRange[k].hi);
            s = $signed(aiSample[k]);
            e = (s > hi) ? hi : (s < lo) ? lo : s;
            rdchk(IOC_IDX_AI, 8'(k + 1), e & 32'hFFFF);
        end
        $display("analog input test done");
        for (int k = 0; k < 8; k++) begin
            aoCode[k] = (int'($urandom % 2001) - 1000) & 32'hFFFF;
            aoMode[k] = (k % 3 == 0) ? 1 : (k % 3 == 1) ? 2 : 0;
            aoFv[k] = $urandom & 32'hFFFF;
            acc(1'b1, IOC_IDX_AO, 8'(k + 1), aoCode[k][15:0]);
            acc(1'b1, IOC_IDX_AO_MODE, 8'(k + 1), aoMode[k][15:0]);
            acc(1'b1, IOC_IDX_AO_FVAL, 8'(k + 1), aoFv[k][15:0]);
            chk(aoOut[k], aoCode[k]);
        end
        evt(1'b1);
        for (int k = 0; k < 8; k++) begin
            if (aoMode[k] == 1) aoCode[k] = aoFv[k];
            chk(aoOut[k], aoCode[k]);
            rdchk(IOC_IDX_AO, 8'(k + 1), aoCode[k]);
            rdchk(IOC_IDX_AO_MODE, 8'(k + 1), aoMode[k]);
        end
        acc(1'b0, IOC_IDX_AO, 8'h09, 16'h0000);
        chk(er, 1);
        $display("analog output test done");
        // reset in mid-run must clear everything again
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        chk(doOut, 0);
        chk(aoOut[0], 0);
        rdchk(IOC_IDX_DO_MASK, 1, 0);
        rdchk(IOC_IDX_AO_FVAL, 1, 0);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule

bind ioc_io_image ioc_io_image_checker chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .odReq(odReq), .odRsp(odRsp),
    .busOff(busOff), .guardFail(guardFail), .doOut(doOut), .aoOut(aoOut));
